// File: verilog/irq_ack_pkg.sv
// Package with the register map, field positions and carrier types of the I2C ack/irq block.
package irq_ack_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_MODE = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // ----------------------------------------------------------------
  // Field positions of the interrupt enable and acknowledge control register
  // ----------------------------------------------------------------
  localparam int CTRL_RX_IE = 5;
  localparam int CTRL_NAK_IE = 4;
  localparam int CTRL_STOP_IE = 3;
  localparam int CTRL_ACK_CHK = 2;
  localparam int CTRL_RX_ACK = 1;
  localparam int CTRL_TX_ACK = 0;

  // ----------------------------------------------------------------
  // Field positions of the bus status register and the event registers
  // ----------------------------------------------------------------
  localparam int ST_RX_FULL = 5;
  localparam int ST_NO_ACK = 4;
  localparam int ST_STOP = 3;
  localparam int ST_ARB_LOST = 2;
  localparam int EV_RX_DONE = 0;
  localparam int EV_NO_ACK = 1;
  localparam int EV_STOP = 2;
  localparam int EV_ARB_LOST = 3;
  localparam int EV_W = 4;

  // ----------------------------------------------------------------
  // Reset values and link framing
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [3:0] EV_RESET = 4'h0;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic receive_irq_enable;
    logic no_ack_irq_enable;
    logic stop_detect_irq_enable;
    logic ack_check_select;
    logic received_ack_bit;
    logic transmit_ack_bit;
  } ctrl_s;

  typedef struct packed {
    logic receive_full_flag;
    logic no_ack_flag;
    logic stop_flag;
    logic arbitration_lost_flag;
  } status_s;

endpackage

// File: verilog/sync2.sv
// Two-flop synchroniser for signals that arrive from outside the core clock domain.
`timescale 1ns/1ps

module sync2 #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // The first stage feeds only the second stage, never any logic.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // sync2

// File: verilog/i2c_irq_enable_ack_control.sv
// I2C byte engine with interrupt enable and acknowledge control, Wishbone register slave.
//
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps

module i2c_irq_enable_ack_control (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic receive_full_irq,
  output logic no_ack_irq,
  output logic stop_detect_irq,
  output logic irq
);

  // ----------------------------------------------------------------
  // Pin synchronisation and bus condition detection
  // ----------------------------------------------------------------
  logic [1:0] pins_s;
  logic scl_q;
  logic sda_q;

  sync2 #(
    .WIDTH(2),
    .RESET_VAL(2'h3)
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in({scl_i, sda_i}),
    .sync_out(pins_s)
  );

  wire scl_s = pins_s[1];
  wire sda_s = pins_s[0];
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_det = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_det = scl_s & scl_q & ~sda_q & sda_s;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  irq_ack_pkg::ctrl_s ctrl_q;
  irq_ack_pkg::status_s stat_q;
  logic [7:0] rx_data_q;
  logic [7:0] tx_data_q;
  logic transmit_mode_q;
  logic [irq_ack_pkg::EV_W-1:0] ev_q;
  logic [irq_ack_pkg::EV_W-1:0] mask_q;

  // ----------------------------------------------------------------
  // Link engine state
  // ----------------------------------------------------------------
  logic active_q;
  logic halt_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_register;
  logic [7:0] tx_shift_q;

  // ----------------------------------------------------------------
  // Wishbone decode
  // ----------------------------------------------------------------
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_en = bus_req & wb_we_i & wb_sel_i[0];
  wire rd_en = bus_req & ~wb_we_i;
  wire hit_ctrl = wb_adr_i == irq_ack_pkg::OFS_CTRL;
  wire hit_stat = wb_adr_i == irq_ack_pkg::OFS_STATUS;
  wire hit_data = wb_adr_i == irq_ack_pkg::OFS_DATA;
  wire hit_mode = wb_adr_i == irq_ack_pkg::OFS_MODE;
  wire hit_ev = wb_adr_i == irq_ack_pkg::OFS_IRQ_STAT;
  wire hit_mask = wb_adr_i == irq_ack_pkg::OFS_IRQ_MASK;
  wire [7:0] wd = wb_dat_i[7:0];

  wire [7:0] ctrl_rd = {2'b00, ctrl_q};
  wire [7:0] stat_rd = {2'b00, stat_q, 2'b00};
  wire [7:0] rd_mux =
    hit_ctrl ? ctrl_rd :
    hit_stat ? stat_rd :
    hit_data ? rx_data_q :
    hit_mode ? {7'h00, transmit_mode_q} :
    hit_ev ? {4'h0, ev_q} :
    hit_mask ? {4'h0, mask_q} : 8'h00;

  // ----------------------------------------------------------------
  // Link decisions
  // ----------------------------------------------------------------
  wire in_ack_slot = bit_cnt_q == irq_ack_pkg::ACK_SLOT;
  wire rise_data = active_q & scl_rise & ~in_ack_slot;
  wire rise_ack = active_q & scl_rise & in_ack_slot;
  // A transmitter that is still sending never starts over a pending no-ack.
  wire tx_ok = transmit_mode_q & ~halt_q & ~stat_q.no_ack_flag;
  // A released one seen low means another driver won the bus.
  wire arb_lost = rise_data & tx_ok & tx_shift_q[7] & ~sda_s;
  wire byte_done = rise_ack & ~transmit_mode_q;
  // Ack value one stops the stream only when checking is selected.
  wire nack_hit = rise_ack & tx_ok & ctrl_q.ack_check_select & sda_s;
  wire [7:0] shift_next = {shift_register[6:0], sda_s};
  // Output enable chosen for the bit that follows the falling edge. Past the first bit the
  // shifter moves on that same edge, so the bit one below the top is the one that goes out.
  wire tx_bit_next = (bit_cnt_q == 4'h0) ? tx_shift_q[7] : tx_shift_q[6];
  wire drive_low_tx = tx_ok & ~in_ack_slot & ~tx_bit_next;
  wire drive_low_rx = ~transmit_mode_q & in_ack_slot & ~ctrl_q.transmit_ack_bit;
  wire oe_next = active_q & (drive_low_tx | drive_low_rx);

  // ----------------------------------------------------------------
  // Event detection for the sticky interrupt status
  // ----------------------------------------------------------------
  wire [irq_ack_pkg::EV_W-1:0] ev_set = {arb_lost, stop_det, nack_hit, byte_done};
  wire [irq_ack_pkg::EV_W-1:0] ev_clr = (wr_en & hit_ev) ? wd[irq_ack_pkg::EV_W-1:0] :
                                        {irq_ack_pkg::EV_W{1'b0}};

  // Status flags: writing zero clears, a hardware set in the same cycle wins.
  wire st_wr = wr_en & hit_stat;
  wire rx_full_clr = (st_wr & ~wd[irq_ack_pkg::ST_RX_FULL]) | (rd_en & hit_data);
  wire no_ack_clr = st_wr & ~wd[irq_ack_pkg::ST_NO_ACK];
  wire stop_clr = st_wr & ~wd[irq_ack_pkg::ST_STOP];
  wire arb_clr = st_wr & ~wd[irq_ack_pkg::ST_ARB_LOST];

  // ----------------------------------------------------------------
  // Bus slave: one wait state, read data registered with ack
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= rd_en ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= irq_ack_pkg::CTRL_RESET[5:0];
      tx_data_q <= irq_ack_pkg::DATA_RESET;
      transmit_mode_q <= 1'b0;
      mask_q <= irq_ack_pkg::EV_RESET;
      ev_q <= irq_ack_pkg::EV_RESET;
    end
    else
    begin
      if (wr_en & hit_ctrl)
      begin
        ctrl_q.receive_irq_enable <= wd[irq_ack_pkg::CTRL_RX_IE];
        ctrl_q.no_ack_irq_enable <= wd[irq_ack_pkg::CTRL_NAK_IE];
        ctrl_q.stop_detect_irq_enable <= wd[irq_ack_pkg::CTRL_STOP_IE];
        ctrl_q.ack_check_select <= wd[irq_ack_pkg::CTRL_ACK_CHK];
        ctrl_q.transmit_ack_bit <= wd[irq_ack_pkg::CTRL_TX_ACK];
      end
      // Software cannot touch the captured ack, only the link can.
      if (rise_ack & transmit_mode_q)
      begin
        ctrl_q.received_ack_bit <= sda_s;
      end
      if (wr_en & hit_data)
      begin
        tx_data_q <= wd;
      end
      if (wr_en & hit_mode)
      begin
        transmit_mode_q <= wd[0];
      end
      if (wr_en & hit_mask)
      begin
        mask_q <= wd[irq_ack_pkg::EV_W-1:0];
      end
      ev_q <= (ev_q & ~ev_clr) | ev_set;
    end
  end

  // ----------------------------------------------------------------
  // Bus status flags
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat_q <= '0;
    end
    else
    begin
      stat_q.receive_full_flag <= byte_done | (stat_q.receive_full_flag & ~rx_full_clr);
      stat_q.no_ack_flag <= nack_hit | (stat_q.no_ack_flag & ~no_ack_clr);
      stat_q.stop_flag <= stop_det | (stat_q.stop_flag & ~stop_clr);
      stat_q.arbitration_lost_flag <= arb_lost | (stat_q.arbitration_lost_flag & ~arb_clr);
    end
  end

  // ----------------------------------------------------------------
  // Link byte engine
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      active_q <= 1'b0;
      halt_q <= 1'b0;
      bit_cnt_q <= 4'h0;
      shift_register <= 8'h00;
      tx_shift_q <= 8'hff;
      rx_data_q <= irq_ack_pkg::DATA_RESET;
    end
    else
    begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      if (start_det | stop_det)
      begin
        active_q <= start_det;
        halt_q <= 1'b0;
        bit_cnt_q <= 4'h0;
        tx_shift_q <= tx_data_q;
      end
      else if (rise_data)
      begin
        shift_register <= shift_next;
        bit_cnt_q <= bit_cnt_q + 4'h1;
        halt_q <= halt_q | arb_lost;
      end
      else if (rise_ack)
      begin
        bit_cnt_q <= 4'h0;
        tx_shift_q <= tx_data_q;
        halt_q <= halt_q | nack_hit;
        if (byte_done)
        begin
          rx_data_q <= shift_register;
        end
      end
      else if (active_q & scl_fall & ~in_ack_slot & (bit_cnt_q != 4'h0))
      begin
        tx_shift_q <= {tx_shift_q[6:0], 1'b1};
      end
    end
  end

  // ----------------------------------------------------------------
  // Data line drive, open drain: only ever pulls low
  // ----------------------------------------------------------------
  // The enable takes a new value only on a falling clock; start, stop, lost arbitration and a checked no-ack clear it at once, with the clock high.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sda_oe <= 1'b0;
      sda_o <= 1'b0;
    end
    else
    begin
      sda_o <= 1'b0;
      if (start_det | stop_det | arb_lost | nack_hit)
      begin
        sda_oe <= 1'b0;
      end
      else if (scl_fall)
      begin
        sda_oe <= oe_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------
  wire rx_req = stat_q.receive_full_flag & ctrl_q.receive_irq_enable;
  wire nak_src = stat_q.no_ack_flag | stat_q.arbitration_lost_flag;
  wire nak_req = nak_src & ctrl_q.no_ack_irq_enable;
  wire stop_req = stat_q.stop_flag & ctrl_q.stop_detect_irq_enable;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      receive_full_irq <= 1'b0;
      no_ack_irq <= 1'b0;
      stop_detect_irq <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      receive_full_irq <= rx_req;
      no_ack_irq <= nak_req;
      stop_detect_irq <= stop_req;
      irq <= |(ev_q & mask_q);
    end
  end

endmodule // i2c_irq_enable_ack_control

// File: dv/i2c_irq_props.sv
// Checker of bus handshake and interrupt gating at the block ports.
`timescale 1ns/1ps

module i2c_irq_props (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic sda_o,
  input wire logic receive_full_irq,
  input wire logic no_ack_irq,
  input wire logic stop_detect_irq,
  input wire logic irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence bus_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence ctrl_wr;
    bus_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == irq_ack_pkg::OFS_CTRL);
  endsequence

  ack_once_a: assert property (bus_take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack is not one pulse after a request");
  ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without a request");
  dat_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside the ack cycle");
  sda_low_a: assert property (sda_o == 1'b0)
    else $error("data pin driven high");
  rx_gate_a: assert property (
    ctrl_wr ##0 !wb_dat_i[irq_ack_pkg::CTRL_RX_IE] |=> ##1 !receive_full_irq)
    else $error("receive request stays after disable");
  nak_gate_a: assert property (
    ctrl_wr ##0 !wb_dat_i[irq_ack_pkg::CTRL_NAK_IE] |=> ##1 !no_ack_irq)
    else $error("no-ack request stays after disable");
  stop_gate_a: assert property (
    ctrl_wr ##0 !wb_dat_i[irq_ack_pkg::CTRL_STOP_IE] |=> ##1 !stop_detect_irq)
    else $error("stop request stays after disable");
  mask_gate_a: assert property (
    bus_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == irq_ack_pkg::OFS_IRQ_MASK
    && wb_dat_i[3:0] == 4'h0) |=> ##1 !irq)
    else $error("interrupt stays with all masked");
endmodule // i2c_irq_props

bind i2c_irq_enable_ack_control i2c_irq_props i_props (.core_clk(core_clk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .sda_o(sda_o), .receive_full_irq(receive_full_irq), .no_ack_irq(no_ack_irq),
  .stop_detect_irq(stop_detect_irq), .irq(irq));

// File: dv/i2c_master_model.sv
// Behavioural I2C bus master driving the link clock and data line.
`timescale 1ns/1ps

module i2c_master_model (
  input wire logic core_clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  logic rel_q;
  // Open drain with pull-up, so a released line reads high.
  assign sda = rel_q && !sda_oe;

  initial
  begin
    scl = 1'b1;
    rel_q = 1'b1;
  end

  // Half of the 200 ns link period; the clock stands high between frames.
  task half;
    repeat (4) @(posedge core_clk);
  endtask

  task start;
    rel_q <= 1'b1;
    scl <= 1'b1;
    half();
    rel_q <= 1'b0;
    half();
    scl <= 1'b0;
  endtask

  task stop;
    rel_q <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    rel_q <= 1'b1;
    half();
  endtask

  // Eight data bits then the ack slot, most significant first.
  task xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      rel_q <= tx[i];
      half();
      scl <= 1'b1;
      half();
      rx[i] = sda;
      scl <= 1'b0;
    end
  endtask
endmodule // i2c_master_model

// File: dv/tb.sv
// Self-checking bench of the I2C interrupt enable and ack control block.
`timescale 1ns/1ps

module tb;
  logic core_clk = 1'b0;
  logic rst_n, cyc, stb, we, ack, scl, sda, sda_o, sda_oe, rx_irq, nak_irq, stp_irq, irq;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wd, rd_o, rdat;
  logic [8:0] got;
  int mismatches, compares;

  always #12.5 core_clk = ~core_clk;

  i2c_irq_enable_ack_control i_dut (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
    .wb_dat_o(rd_o), .wb_ack_o(ack), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .receive_full_irq(rx_irq), .no_ack_irq(nak_irq),
    .stop_detect_irq(stp_irq), .irq(irq));
  i2c_master_model i_link (.core_clk(core_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

  task stop_test;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Classic single cycle; the answer is awaited under a bounded count.
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= {24'h0, d};
    @(posedge core_clk);
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 20)
    begin
      mismatches++;
      $display("bus timeout at %0t", $time);
      stop_test();
    end
    rdat = rd_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 8'h00);
    chk(rdat, e);
  endtask

  task t_regs;
    rd(irq_ack_pkg::OFS_CTRL, 32'h0);
    wr(irq_ack_pkg::OFS_CTRL, 8'hff);
    rd(irq_ack_pkg::OFS_CTRL, 32'h3d);
    rd(8'h18, 32'h0);
    $display("register test done");
  endtask

  task t_rx;
    for (int a = 0; a < 2; a++)
    begin
      wr(irq_ack_pkg::OFS_MODE, 8'h00);
      wr(irq_ack_pkg::OFS_CTRL, 8'h28 | 8'(a));
      wr(irq_ack_pkg::OFS_IRQ_MASK, 8'h01);
      i_link.start();
      i_link.xfer({8'ha5, 1'b1}, got);
      i_link.half();
      chk(32'(got[0]), 32'(a));
      chk(32'(rx_irq), 32'h1);
      chk(32'(irq), 32'h1);
      rd(irq_ack_pkg::OFS_DATA, 32'ha5);
      i_link.half();
      chk(32'(rx_irq), 32'h0);
      wr(irq_ack_pkg::OFS_IRQ_STAT, 8'h01);
      i_link.half();
      chk(32'(irq), 32'h0);
      i_link.stop();
      i_link.half();
      chk(32'(stp_irq), 32'h1);
      wr(irq_ack_pkg::OFS_CTRL, 8'h00);
      i_link.half();
      chk(32'(stp_irq), 32'h0);
      wr(irq_ack_pkg::OFS_STATUS, 8'h00);
      wr(irq_ack_pkg::OFS_IRQ_MASK, 8'h00);
    end
    $display("receive test done");
  endtask

  task t_tx;
    wr(irq_ack_pkg::OFS_MODE, 8'h01);
    wr(irq_ack_pkg::OFS_DATA, 8'h3c);
    wr(irq_ack_pkg::OFS_CTRL, 8'h14);
    i_link.start();
    i_link.xfer(9'h1ff, got);
    i_link.half();
    chk(32'(got[8:1]), 32'h3c);
    chk(32'(nak_irq), 32'h1);
    rd(irq_ack_pkg::OFS_CTRL, 32'h16);
    rd(irq_ack_pkg::OFS_STATUS, 32'h10);
    i_link.stop();
    i_link.start();
    i_link.xfer(9'h1ff, got);
    chk(32'(got), 32'h1ff);
    // The flag is cleared only once the frame is over, or the engine would resume mid-frame.
    i_link.stop();
    wr(irq_ack_pkg::OFS_STATUS, 8'h08);
    i_link.half();
    chk(32'(nak_irq), 32'h0);
    wr(irq_ack_pkg::OFS_CTRL, 8'h10);
    i_link.start();
    i_link.xfer(9'h1ff, got);
    i_link.half();
    chk(32'(got[8:1]), 32'h3c);
    rd(irq_ack_pkg::OFS_STATUS, 32'h08);
    // With the check off the device streams the reloaded byte; pulling its third bit low
    // loses arbitration, which also releases the line for the closing stop.
    i_link.xfer(9'h000, got);
    i_link.half();
    chk(32'(nak_irq), 32'h1);
    rd(irq_ack_pkg::OFS_STATUS, 32'h0c);
    i_link.stop();
    wr(irq_ack_pkg::OFS_CTRL, 8'h00);
    $display("transmit test done");
  endtask

  initial
  begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h1;
    wd = 32'h0;
    mismatches = 0;
    compares = 0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_rx();
    t_tx();
    stop_test();
  end
endmodule // tb
